// File: design/mbm_map.v
// modbus request decoder mapping function code and offset to data tables
`timescale 1ns/1ps
// Functional notes
// - a reference's leading digit picks the area, the rest is 1-based.
// - discrete refs: inputs 10001, global 13001, sys 14001, keys 15001.
// - fc2 maps inputs@0, global inputs@3000, sys bits@4000, keys@5000.
// - fc1 maps outputs@0, internal@3000, temporary@6000, global out@9000.
// - fc5 and fc15 write the same coil tables and offsets that fc1 reads.
// - fc4 maps analog inputs@0, global analog@3000, system words@4000.
// - fc3/6/16: aout@0, regs 40513+, @3000, global aout@6000, @10000.
module mbm_map #(
  parameter ADDR_W = 16
) (
  input  wire              i_mclk,
  input  wire              i_reset_n,
  input  wire              i_req_valid,
  input  wire [7:0]        i_req_func,
  input  wire [15:0]       i_req_offset,
  input  wire [15:0]       i_req_count,
  input  wire              i_ref_valid,
  input  wire [19:0]       i_ref_number,
  output reg               o_map_valid,
  output reg               o_map_write,
  output reg  [3:0]        o_map_table,
  output reg  [ADDR_W-1:0] o_map_index,
  output reg  [15:0]       o_map_count,
  output reg               o_exc_valid,
  output reg  [7:0]        o_exc_func,
  output reg  [7:0]        o_exc_code,
  output reg               o_ref_done,
  output reg  [7:0]        o_ref_func,
  output reg  [15:0]       o_ref_offset,
  output reg               o_ref_err
);
`include "mbm_map_regs.vh"

////////////////////////////////////////////////////////////////////////////
// area lookup
reg  [3:0]  tbl;
reg  [15:0] base;
reg  [16:0] len;
reg  [15:0] idx0;
reg         fc_ok;
reg         wr;
wire [16:0] ofs17 = {1'b0, i_req_offset};
wire [16:0] end17 = ofs17 + {1'b0, i_req_count};

// true when [ofs, ofs+cnt) sits inside [b, b+l)
function in_area;
  input [16:0] o;
  input [16:0] e;
  input [15:0] b;
  input [16:0] l;
  begin
    in_area = (o >= {1'b0, b}) && (e <= ({1'b0, b} + l));
  end
endfunction

always @* begin
  tbl   = `MBM_TBL_NONE;
  base  = `MBM_OFS_0;
  len   = 17'h00000;
  idx0  = 16'h0000;
  fc_ok = 1'b1;
  wr    = 1'b0;
  case (i_req_func)
    `MBM_FC_RD_DISC: begin
      if (in_area(ofs17, end17, `MBM_OFS_0, `MBM_LEN_1024)) begin
        tbl  = `MBM_TBL_INPUT;
        base = `MBM_OFS_0;
      end else if (in_area(ofs17, end17, `MBM_OFS_3000, `MBM_LEN_256)) begin
        tbl  = `MBM_TBL_GIN;
        base = `MBM_OFS_3000;
      end else if (in_area(ofs17, end17, `MBM_OFS_4000, `MBM_LEN_256)) begin
        tbl  = `MBM_TBL_SYSBIT;
        base = `MBM_OFS_4000;
      end else if (in_area(ofs17, end17, `MBM_OFS_5000, `MBM_LEN_10)) begin
        tbl  = `MBM_TBL_KEY;
        base = `MBM_OFS_5000;
      end
    end
    `MBM_FC_RD_COILS, `MBM_FC_WR_COIL, `MBM_FC_WR_COILS: begin
      wr = (i_req_func != `MBM_FC_RD_COILS);
      if (in_area(ofs17, end17, `MBM_OFS_0, `MBM_LEN_1024)) begin
        tbl  = `MBM_TBL_OUTPUT;
        base = `MBM_OFS_0;
      end else if (in_area(ofs17, end17, `MBM_OFS_3000, `MBM_LEN_1024)) begin
        tbl  = `MBM_TBL_INTBIT;
        base = `MBM_OFS_3000;
      end else if (in_area(ofs17, end17, `MBM_OFS_6000, `MBM_LEN_1024)) begin
        tbl  = `MBM_TBL_TMPBIT;
        base = `MBM_OFS_6000;
      end else if (in_area(ofs17, end17, `MBM_OFS_9000, `MBM_LEN_256)) begin
        tbl  = `MBM_TBL_GOUT;
        base = `MBM_OFS_9000;
      end
    end
    `MBM_FC_RD_INREG: begin
      if (in_area(ofs17, end17, `MBM_OFS_0, `MBM_LEN_256)) begin
        tbl  = `MBM_TBL_AIN;
        base = `MBM_OFS_0;
      end else if (in_area(ofs17, end17, `MBM_OFS_3000, `MBM_LEN_32)) begin
        tbl  = `MBM_TBL_GAIN;
        base = `MBM_OFS_3000;
      end else if (in_area(ofs17, end17, `MBM_OFS_4000, `MBM_LEN_200)) begin
        tbl  = `MBM_TBL_SYSWORD;
        base = `MBM_OFS_4000;
      end
    end
    `MBM_FC_RD_HOLD, `MBM_FC_WR_REG, `MBM_FC_WR_REGS: begin
      wr = (i_req_func != `MBM_FC_RD_HOLD);
      // analog outputs below ref 40513, general regs from there on
      if (in_area(ofs17, end17, `MBM_OFS_0, `MBM_LEN_AOUT_LOW)) begin
        tbl  = `MBM_TBL_AOUT;
        base = `MBM_OFS_0;
      end else if (in_area(ofs17, end17, `MBM_OFS_GR_LOW,
                           `MBM_LEN_GR_LOW)) begin
        tbl  = `MBM_TBL_GENREG;
        base = `MBM_OFS_GR_LOW;
      end else if (in_area(ofs17, end17, `MBM_OFS_3000, `MBM_LEN_2048)) begin
        tbl  = `MBM_TBL_GENREG;
        base = `MBM_OFS_3000;
        idx0 = `MBM_GR_IDX_3000;
      end else if (in_area(ofs17, end17, `MBM_OFS_6000, `MBM_LEN_32)) begin
        tbl  = `MBM_TBL_GAOUT;
        base = `MBM_OFS_6000;
      end else if (in_area(ofs17, end17, `MBM_OFS_10000,
                           `MBM_LEN_5000)) begin
        tbl  = `MBM_TBL_GENREG;
        base = `MBM_OFS_10000;
        idx0 = `MBM_GR_IDX_10000;
      end
    end
    default: fc_ok = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// request answer, one cycle after the strobe
wire [15:0] rel = i_req_offset - base + idx0;

always @(posedge i_mclk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_map_valid <= 1'b0;
    o_map_write <= 1'b0;
    o_map_table <= `MBM_TBL_NONE;
    o_map_index <= {ADDR_W{1'b0}};
    o_map_count <= 16'h0000;
    o_exc_valid <= 1'b0;
    o_exc_func  <= 8'h00;
    o_exc_code  <= 8'h00;
  end else begin
    o_map_valid <= 1'b0;
    o_exc_valid <= 1'b0;
    if (i_req_valid) begin
      // zero count treated as out of range, no empty transfer
      if (!fc_ok) begin
        o_exc_valid <= 1'b1;
        o_exc_func  <= i_req_func | `MBM_EXC_FLAG;
        o_exc_code  <= `MBM_EXC_FUNC;
      end else if (tbl == `MBM_TBL_NONE || i_req_count == 16'h0000) begin
        o_exc_valid <= 1'b1;
        o_exc_func  <= i_req_func | `MBM_EXC_FLAG;
        o_exc_code  <= `MBM_EXC_ADDR;
      end else begin
        o_map_valid <= 1'b1;
        o_map_write <= wr;
        o_map_table <= tbl;
        o_map_index <= rel[ADDR_W-1:0];
        o_map_count <= i_req_count;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// reference number to function code and zero-based offset
reg  [7:0]  rfc;
reg  [19:0] rofs;
reg         rbad;

always @* begin
  rfc  = 8'h00;
  rofs = 20'h00000;
  rbad = 1'b0;
  // expanded six-digit holding refs first, then leading digit
  if (i_ref_number >= `MBM_REF_HOLD_EXP) begin
    rfc  = `MBM_FC_RD_HOLD;
    rofs = i_ref_number - `MBM_REF_HOLD_EXP + {4'h0, `MBM_OFS_10000};
  end else if (i_ref_number >= `MBM_REF_HOLD) begin
    rfc  = `MBM_FC_RD_HOLD;
    rofs = i_ref_number - `MBM_REF_HOLD;
  end else if (i_ref_number >= `MBM_REF_INREG) begin
    rfc  = `MBM_FC_RD_INREG;
    rofs = i_ref_number - `MBM_REF_INREG;
  end else if (i_ref_number >= `MBM_REF_DISC) begin
    rfc  = `MBM_FC_RD_DISC;
    rofs = i_ref_number - `MBM_REF_DISC;
  end else if (i_ref_number >= `MBM_REF_COIL) begin
    rfc  = `MBM_FC_RD_COILS;
    rofs = i_ref_number - `MBM_REF_COIL;
  end else begin
    rbad = 1'b1;
  end
  if (rofs[19:16] != 4'h0) rbad = 1'b1;
end

always @(posedge i_mclk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_ref_done   <= 1'b0;
    o_ref_func   <= 8'h00;
    o_ref_offset <= 16'h0000;
    o_ref_err    <= 1'b0;
  end else begin
    o_ref_done <= i_ref_valid;
    if (i_ref_valid) begin
      o_ref_func   <= rfc;
      o_ref_offset <= rofs[15:0];
      o_ref_err    <= rbad;
    end
  end
end

endmodule // mbm_map

// File: design/mbm_map_regs.vh
// constants for the modbus data table mapper
`ifndef MBM_MAP_REGS_VH
`define MBM_MAP_REGS_VH
// function codes
`define MBM_FC_RD_COILS   8'h01
`define MBM_FC_RD_DISC    8'h02
`define MBM_FC_RD_HOLD    8'h03
`define MBM_FC_RD_INREG   8'h04
`define MBM_FC_WR_COIL    8'h05
`define MBM_FC_WR_REG     8'h06
`define MBM_FC_WR_COILS   8'h0f
`define MBM_FC_WR_REGS    8'h10
// exception codes
`define MBM_EXC_FUNC      8'h01
`define MBM_EXC_ADDR      8'h02
`define MBM_EXC_FLAG      8'h80
// table selectors
`define MBM_TBL_INPUT     4'h0
`define MBM_TBL_GIN       4'h1
`define MBM_TBL_SYSBIT    4'h2
`define MBM_TBL_KEY       4'h3
`define MBM_TBL_OUTPUT    4'h4
`define MBM_TBL_INTBIT    4'h5
`define MBM_TBL_TMPBIT    4'h6
`define MBM_TBL_GOUT      4'h7
`define MBM_TBL_AIN       4'h8
`define MBM_TBL_GAIN      4'h9
`define MBM_TBL_SYSWORD   4'ha
`define MBM_TBL_AOUT      4'hb
`define MBM_TBL_GENREG    4'hc
`define MBM_TBL_GAOUT     4'hd
`define MBM_TBL_NONE      4'hf
// area bases (zero-based offsets) and sizes
`define MBM_OFS_0         16'h0000
`define MBM_OFS_3000      16'h0bb8
`define MBM_OFS_4000      16'h0fa0
`define MBM_OFS_5000      16'h1388
`define MBM_OFS_6000      16'h1770
`define MBM_OFS_9000      16'h2328
`define MBM_OFS_10000     16'h2710
`define MBM_OFS_GR_LOW    16'h0200
`define MBM_LEN_1024      17'h00400
`define MBM_LEN_256       17'h00100
`define MBM_LEN_10        17'h0000a
`define MBM_LEN_32        17'h00020
`define MBM_LEN_200       17'h000c8
`define MBM_LEN_2048      17'h00800
`define MBM_LEN_5000      17'h01388
`define MBM_LEN_AOUT_LOW  17'h00200
`define MBM_LEN_GR_LOW    17'h009b8
// general register index where each window begins
`define MBM_GR_IDX_3000   16'h0000
`define MBM_GR_IDX_10000  16'h0000
// traditional reference digit bases
`define MBM_REF_COIL      20'h00001
`define MBM_REF_DISC      20'h02711
`define MBM_REF_INREG     20'h07531
`define MBM_REF_HOLD      20'h09c41
`define MBM_REF_HOLD_EXP  20'h64191
`endif

// File: dv/mbm_map_checker.sv
// assertions for the modbus data table mapper
`timescale 1ns/1ps
`include "mbm_map_regs.vh"
module mbm_map_checker #(
  parameter ADDR_W = 16
) (
  input wire              i_mclk,
  input wire              i_reset_n,
  input wire              i_req_valid,
  input wire [7:0]        i_req_func,
  input wire [15:0]       i_req_offset,
  input wire [15:0]       i_req_count,
  input wire              i_ref_valid,
  input wire              o_map_valid,
  input wire              o_map_write,
  input wire [3:0]        o_map_table,
  input wire [ADDR_W-1:0] o_map_index,
  input wire [15:0]       o_map_count,
  input wire              o_exc_valid,
  input wire [7:0]        o_exc_func,
  input wire [7:0]        o_exc_code,
  input wire              o_ref_done
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  wire wr_fc = i_req_func inside {8'h05, 8'h06, 8'h0f, 8'h10};
  wire fc_ok = wr_fc || i_req_func inside {8'h01, 8'h02, 8'h03, 8'h04};
  wire [16:0] span_end = {1'b0, i_req_offset} + {1'b0, i_req_count};
  // key bits are the smallest area, so an off-by-one shows first here
  wire key_hit = i_req_valid && i_req_func == 8'h02 && i_req_count != 0
    && i_req_offset >= `MBM_OFS_5000 && span_end <= 17'h01392;
  sequence s_req_ok; i_req_valid && fc_ok; endsequence
  sequence s_map; o_map_valid && !o_exc_valid; endsequence
  property p_one; i_req_valid |=> o_map_valid != o_exc_valid; endproperty
  property p_idle; !i_req_valid |=> !o_map_valid && !o_exc_valid; endproperty
  property p_badfc;
    i_req_valid && !fc_ok |=> o_exc_valid && o_exc_code == `MBM_EXC_FUNC;
  endproperty
  property p_cnt0;
    s_req_ok ##0 i_req_count == 16'h0000 |=> o_exc_code == `MBM_EXC_ADDR;
  endproperty
  property p_efunc;
    i_req_valid |=> !o_exc_valid || o_exc_func == ($past(i_req_func) | 8'h80);
  endproperty
  property p_wr;
    s_req_ok |=> !o_map_valid || o_map_write == $past(wr_fc);
  endproperty
  property p_cnt;
    s_req_ok |=> !o_map_valid || o_map_count == $past(i_req_count);
  endproperty
  property p_key;
    key_hit |=> s_map ##0 o_map_table == `MBM_TBL_KEY
      && o_map_index == $past(i_req_offset) - `MBM_OFS_5000;
  endproperty
  property p_ref; i_ref_valid |=> o_ref_done; endproperty
  a_one: assert property (p_one) else $error("answer not unique");
  a_idle: assert property (p_idle) else $error("answer unasked");
  a_badfc: assert property (p_badfc) else $error("bad code kept");
  a_cnt0: assert property (p_cnt0) else $error("zero count kept");
  a_efunc: assert property (p_efunc) else $error("exc func wrong");
  a_wr: assert property (p_wr) else $error("write flag wrong");
  a_cnt: assert property (p_cnt) else $error("count wrong");
  a_key: assert property (p_key) else $error("key map wrong");
  a_ref: assert property (p_ref) else $error("ref not done");
endmodule // mbm_map_checker
bind mbm_map mbm_map_checker #(.ADDR_W(ADDR_W)) u_chk (.i_mclk, .i_reset_n,
  .i_req_valid, .i_req_func, .i_req_offset, .i_req_count, .i_ref_valid,
  .o_map_valid, .o_map_write, .o_map_table, .o_map_index, .o_map_count,
  .o_exc_valid, .o_exc_func, .o_exc_code, .o_ref_done);

// File: dv/mbm_master_model.sv
// request-side master model for the mapper
`timescale 1ns/1ps
module mbm_master_model (
  input  wire        i_mclk,
  output reg         o_req_valid,
  output reg  [7:0]  o_req_func,
  output reg  [15:0] o_req_offset,
  output reg  [15:0] o_req_count,
  output reg         o_ref_valid,
  output reg  [19:0] o_ref_number
);
  initial begin
    {o_req_valid, o_req_func, o_req_offset, o_req_count} = 41'h0;
    {o_ref_valid, o_ref_number} = 21'h0;
  end
  // explicit code with zero-based offset
  task req(input [7:0] f, input [15:0] o, input [15:0] c);
    begin
      @(posedge i_mclk);
      {o_req_valid, o_req_func, o_req_offset, o_req_count} <= {1'b1, f, o, c};
      @(posedge i_mclk);
      // released fields flip so stale values are never trusted
      {o_req_valid, o_req_func, o_req_offset, o_req_count} <= {1'b0, ~f, ~o, ~c};
    end
  endtask
  task cvt(input [19:0] n);
    begin
      @(posedge i_mclk);
      {o_ref_valid, o_ref_number} <= {1'b1, n};
      @(posedge i_mclk);
      {o_ref_valid, o_ref_number} <= {1'b0, ~n};
    end
  endtask
endmodule // mbm_master_model

// File: dv/tb_modbus_data_table_mapper.sv
// testbench for the modbus data table mapper
`timescale 1ns/1ps
module tb_modbus_data_table_mapper;
  reg         i_mclk = 1'b0;
  reg         i_reset_n = 1'b0;
  wire        rv, fv, mv, mw, ev, rd, re;
  wire [7:0]  fn, ef, ec, rf;
  wire [15:0] of, cn, mi, mc, ro;
  wire [19:0] rn;
  wire [3:0]  mt;
  integer     error_cnt = 0;
  integer     check_count = 0;
  always #20 i_mclk = ~i_mclk;
  mbm_master_model u_mst (.i_mclk(i_mclk), .o_req_valid(rv), .o_req_func(fn),
    .o_req_offset(of), .o_req_count(cn), .o_ref_valid(fv), .o_ref_number(rn));
  mbm_map u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req_valid(rv),
    .i_req_func(fn), .i_req_offset(of), .i_req_count(cn), .i_ref_valid(fv),
    .i_ref_number(rn), .o_map_valid(mv), .o_map_write(mw), .o_map_table(mt),
    .o_map_index(mi), .o_map_count(mc), .o_exc_valid(ev), .o_exc_func(ef),
    .o_exc_code(ec), .o_ref_done(rd), .o_ref_func(rf), .o_ref_offset(ro),
    .o_ref_err(re));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // x[7] set: exception with code x[3:0], else table x[3:0]
  task rq(input [7:0] f, input [15:0] o, c, input [7:0] x, input [15:0] ix);
    begin
      u_mst.req(f, o, c);
      #1;
      if (x[7]) begin
        chk({ev, mv, ef, ec}, {2'b10, f | 8'h80, 4'h0, x[3:0]});
      end else begin
        chk({ev, mv, mw, mt}, {2'b01, f inside {5, 6, 15, 16}, x[3:0]});
        chk({mi, mc}, {ix, c});
      end
    end
  endtask
  task rf_chk(input [19:0] n, input [7:0] f, input [15:0] o);
    begin
      u_mst.cvt(n);
      #1;
      chk({rd, re, rf, ro}, {1'b1, f == 8'h00, f, o});
    end
  endtask
  task t_disc;
    begin
      rq(8'h02, 16'h03ff, 16'h0001, 8'h00, 16'h03ff);
      rq(8'h02, 16'h0cb7, 16'h0001, 8'h01, 16'h00ff);
      rq(8'h02, 16'h0fa0, 16'h0100, 8'h02, 16'h0000);
      rq(8'h02, 16'h1391, 16'h0001, 8'h03, 16'h0009);
      rq(8'h02, 16'h1391, 16'h0002, 8'h82, 16'h0000);
    end
  endtask
  task t_coil;
    begin
      rq(8'h01, 16'h2427, 16'h0001, 8'h07, 16'h00ff);
      rq(8'h01, 16'h1770, 16'h0400, 8'h06, 16'h0000);
      rq(8'h05, 16'h0bb8, 16'h0001, 8'h05, 16'h0000);
      rq(8'h0f, 16'h03fe, 16'h0002, 8'h04, 16'h03fe);
    end
  endtask
  task t_words;
    begin
      rq(8'h04, 16'h00ff, 16'h0001, 8'h08, 16'h00ff);
      rq(8'h04, 16'h0bd7, 16'h0001, 8'h09, 16'h001f);
      rq(8'h04, 16'h1067, 16'h0001, 8'h0a, 16'h00c7);
      rq(8'h04, 16'h1068, 16'h0001, 8'h82, 16'h0000);
      rq(8'h03, 16'h00ff, 16'h0001, 8'h0b, 16'h00ff);
      rq(8'h03, 16'h0200, 16'h0001, 8'h0c, 16'h0000);
      rq(8'h06, 16'h0bb8, 16'h0001, 8'h0c, 16'h0000);
      rq(8'h10, 16'h178f, 16'h0001, 8'h0d, 16'h001f);
      rq(8'h03, 16'h3a97, 16'h0001, 8'h0c, 16'h1387);
      rq(8'h03, 16'h13b8, 16'h0001, 8'h82, 16'h0000);
    end
  endtask
  task t_exc;
    begin
      rq(8'h07, 16'h0000, 16'h0001, 8'h81, 16'h0000);
      rq(8'h01, 16'h0000, 16'h0000, 8'h82, 16'h0000);
      rq(8'h01, 16'h03ff, 16'h0002, 8'h82, 16'h0000);
    end
  endtask
  task t_ref;
    begin
      rf_chk(20'h00bb9, 8'h01, 16'h0bb8);
      rf_chk(20'h032c9, 8'h02, 16'h0bb8);
      rf_chk(20'h03a99, 8'h02, 16'h1388);
      rf_chk(20'h07531, 8'h04, 16'h0000);
      rf_chk(20'h09e41, 8'h03, 16'h0200);
      rf_chk(20'h64191, 8'h03, 16'h2710);
      rf_chk(20'h00000, 8'h00, 16'h0000);
    end
  endtask
  task summarize;
    begin
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    t_disc;
    t_coil;
    t_words;
    t_exc;
    t_ref;
    summarize;
  end
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    summarize;
  end
endmodule // tb_modbus_data_table_mapper
